// ===== verilog/pin_sync.sv
package jk_pkg;
  // reset and idle levels
  localparam logic Q_TRUE_RST  = 1'b0;
  localparam logic Q_COMP_RST  = 1'b1;
  localparam logic CLK_IDLE    = 1'b1;
  localparam logic PIN_IDLE_N  = 1'b1;
  localparam logic DATA_IDLE   = 1'b0;
  // number of storage elements
  localparam int   NUM_FF_DEF  = 2;
  // one-hot edge actions
  typedef enum logic [3:0] {
    ACT_HOLD   = 4'h1,
    ACT_SET    = 4'h2,
    ACT_RESET  = 4'h4,
    ACT_TOGGLE = 4'h8
  } jk_action_t;
endpackage : jk_pkg

`timescale 1ns/1ns
module pin_sync
  import jk_pkg::*;
#(
  parameter int        WIDTH    = 1,
  parameter bit [63:0] RST_BITS = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.stage1 = din;
    st_nxt.stage2 = st_r.stage1;
    if (!rst_n) begin
      st_nxt.stage1 = RST_BITS[WIDTH-1:0];
      st_nxt.stage2 = RST_BITS[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign dout = st_r.stage2;

endmodule : pin_sync

// ===== verilog/dual_jk_flip_flop.sv
// Behaviour
// RQ1: two separate elements, each with own clock, data, preset, clear, outputs
// RQ2: state changes only on falling edge of its own edge clock
// RQ3: falling edge: hold, set, reset or toggle by the two data inputs
// RQ4: data levels taken from just before the falling edge decide next state
// RQ5: data may change anywhere if held steady around the falling edge
// RQ6: preset low, clear high: true output high, complement low
// RQ7: clear low, preset high: true output low, complement high
// RQ8: while preset or clear is low, clock edges are ignored
// RQ9: preset and clear act without waiting for a clock edge
// RQ10: preset and clear both low: both outputs high
// RQ11: otherwise the complement output is always the inverse of true output; here it stays high until the third clk after both overrides are released
`timescale 1ns/1ns
module dual_jk_flip_flop
  import jk_pkg::*;
#(
  parameter int NUM_FF = NUM_FF_DEF
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [NUM_FF-1:0] edge_clock_n,
  input  wire logic [NUM_FF-1:0] jk_set,
  input  wire logic [NUM_FF-1:0] jk_reset,
  input  wire logic [NUM_FF-1:0] async_preset_n,
  input  wire logic [NUM_FF-1:0] async_clear_n,
  output logic      [NUM_FF-1:0] q_true,
  output logic      [NUM_FF-1:0] q_comp
);

  localparam int SYNC_W = 5 * NUM_FF;

  // idle pin levels for the synchroniser reset
  localparam bit [63:0] SYNC_RST = 64'({
    {NUM_FF{PIN_IDLE_N}},
    {NUM_FF{PIN_IDLE_N}},
    {NUM_FF{DATA_IDLE}},
    {NUM_FF{DATA_IDLE}},
    {NUM_FF{CLK_IDLE}}
  });

  typedef struct packed {
    logic [NUM_FF-1:0] clk_prev;
    logic [NUM_FF-1:0] set_prev;
    logic [NUM_FF-1:0] reset_prev;
    logic [NUM_FF-1:0] q_true;
    logic [NUM_FF-1:0] q_comp;
  } jk_state_t;

  jk_state_t st_r;
  jk_state_t st_nxt;

  logic [SYNC_W-1:0] sync_out;
  logic [NUM_FF-1:0] clk_s;
  logic [NUM_FF-1:0] set_s;
  logic [NUM_FF-1:0] reset_s;
  logic [NUM_FF-1:0] preset_s_n;
  logic [NUM_FF-1:0] clear_s_n;
  logic [NUM_FF-1:0] q_true_nxt;
  logic [NUM_FF-1:0] q_comp_nxt;

  // every pin passes two flip-flops before use
  pin_sync #(
    .WIDTH    (SYNC_W),
    .RST_BITS (SYNC_RST)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({async_clear_n, async_preset_n, jk_reset, jk_set, edge_clock_n}),
    .dout  (sync_out)
  );

  assign clk_s      = sync_out[0*NUM_FF +: NUM_FF];
  assign set_s      = sync_out[1*NUM_FF +: NUM_FF];
  assign reset_s    = sync_out[2*NUM_FF +: NUM_FF];
  assign preset_s_n = sync_out[3*NUM_FF +: NUM_FF];
  assign clear_s_n  = sync_out[4*NUM_FF +: NUM_FF];

  function automatic jk_action_t decode_action(input logic s, input logic r);
    jk_action_t a;
    a = ACT_HOLD;
    unique case ({s, r})
      2'b00: a = ACT_HOLD;
      2'b10: a = ACT_SET;
      2'b01: a = ACT_RESET;
      2'b11: a = ACT_TOGGLE;
    endcase
    return a;
  endfunction : decode_action

  // RQ1: one independent element per index
  genvar i;
  generate
    for (i = 0; i < NUM_FF; i++) begin : g_ff
      logic       fall;
      jk_action_t act;

      // RQ2: falling edge of own clock only
      assign fall = st_r.clk_prev[i] & ~clk_s[i];
      // RQ4: data from the sample before the edge
      assign act  = decode_action(st_r.set_prev[i], st_r.reset_prev[i]);

      always_comb begin
        q_true_nxt[i] = st_r.q_true[i];
        q_comp_nxt[i] = st_r.q_comp[i];
        // RQ10: both overrides low
        if (!preset_s_n[i] && !clear_s_n[i]) begin
          q_true_nxt[i] = 1'b1;
          q_comp_nxt[i] = 1'b1;
        // RQ6: preset override
        end else if (!preset_s_n[i]) begin
          q_true_nxt[i] = 1'b1;
          q_comp_nxt[i] = 1'b0;
        // RQ7: clear override
        end else if (!clear_s_n[i]) begin
          q_true_nxt[i] = 1'b0;
          q_comp_nxt[i] = 1'b1;
        // RQ8: clocking only with overrides released
        end else if (fall) begin
          // RQ3: edge action
          unique case (act)
            ACT_HOLD: begin
              q_true_nxt[i] = st_r.q_true[i];
            end
            ACT_SET: begin
              q_true_nxt[i] = 1'b1;
            end
            ACT_RESET: begin
              q_true_nxt[i] = 1'b0;
            end
            ACT_TOGGLE: begin
              q_true_nxt[i] = ~st_r.q_true[i];
            end
          endcase
          // RQ11: complement follows
          q_comp_nxt[i] = ~q_true_nxt[i];
        end else begin
          // RQ11: complement restored after dual override
          q_comp_nxt[i] = ~st_r.q_true[i];
        end
      end
    end
  endgenerate

  always_comb begin
    st_nxt            = st_r;
    st_nxt.clk_prev   = clk_s;
    // RQ5: data only matter around the edge
    st_nxt.set_prev   = set_s;
    st_nxt.reset_prev = reset_s;
    // RQ9: overrides act on the third clk after the pin changes, not on an edge clock edge
    st_nxt.q_true     = q_true_nxt;
    st_nxt.q_comp     = q_comp_nxt;
    if (!rst_n) begin
      st_nxt.clk_prev   = {NUM_FF{CLK_IDLE}};
      st_nxt.set_prev   = {NUM_FF{DATA_IDLE}};
      st_nxt.reset_prev = {NUM_FF{DATA_IDLE}};
      st_nxt.q_true     = {NUM_FF{Q_TRUE_RST}};
      st_nxt.q_comp     = {NUM_FF{Q_COMP_RST}};
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign q_true = st_r.q_true;
  assign q_comp = st_r.q_comp;

endmodule : dual_jk_flip_flop

// ===== testbench/jk_chk_sva.sv
`timescale 1ns/1ns
module jk_chk #(
  parameter int NUM_FF = 2
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [NUM_FF-1:0] edge_clock_n,
  input wire logic [NUM_FF-1:0] jk_set,
  input wire logic [NUM_FF-1:0] jk_reset,
  input wire logic [NUM_FF-1:0] async_preset_n,
  input wire logic [NUM_FF-1:0] async_clear_n,
  input wire logic [NUM_FF-1:0] q_true,
  input wire logic [NUM_FF-1:0] q_comp
);
  wire [NUM_FF-1:0] p = async_preset_n;
  wire [NUM_FF-1:0] c = async_clear_n;
  wire [NUM_FF-1:0] t = q_true;
  wire [NUM_FF-1:0] n = q_comp;
  wire              o0 = p[0] & c[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_pre; !p[1] && c[1] |-> ##3 t[1] && !n[1]; endproperty
  property p_clr; p[0] && !c[0] |-> ##3 !t[0] && n[0]; endproperty
  property p_both; !p[0] && !c[0] |-> ##3 t[0] && n[0]; endproperty
  property p_comp; (p[1] && c[1]) [*4] |-> n[1] == !t[1]; endproperty
  property p_tog;
    $fell(edge_clock_n[0]) && jk_set[0] && jk_reset[0] && o0 |-> ##3 t[0] != $past(t[0]);
  endproperty
  property p_set; $fell(edge_clock_n[0]) && jk_set[0] && !jk_reset[0] && o0 |-> ##3 t[0];
  endproperty
  property p_rst; $fell(edge_clock_n[0]) && !jk_set[0] && jk_reset[0] && o0 |-> ##3 !t[0];
  endproperty
  property p_rise; $rose(edge_clock_n[1]) && p[1] && c[1] |-> ##3 $stable(t[1]); endproperty
  a_pre: assert property (p_pre) else $error("preset");
  a_clr: assert property (p_clr) else $error("clear");
  a_both: assert property (p_both) else $error("both low");
  a_comp: assert property (p_comp) else $error("complement");
  a_tog: assert property (p_tog) else $error("toggle");
  a_set: assert property (p_set) else $error("set");
  a_rst: assert property (p_rst) else $error("reset");
  a_rise: assert property (p_rise) else $error("rising edge");
  c_tog: cover property ($fell(edge_clock_n[0]) && jk_set[0] && jk_reset[0]);
  c_both: cover property (p == '0 && c == '0);
  c_pre: cover property (!p[1] && c[1]);
endmodule : jk_chk

// ===== testbench/tb.sv
`timescale 1ns/1ns
module tb;
  import jk_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] ck = 2'h3, j = 2'h0, k = 2'h0, p = 2'h3, c = 2'h3, qt, qc;
  logic [1:0] m = 2'h0, nj, nk, f;
  logic [3:0] ex[$];
  int         n_errors = 0;
  int         cmp_count = 0;
  dual_jk_flip_flop dual_jk_flip_flop_inst (.clk(clk), .rst_n(rst_n), .edge_clock_n(ck),
    .jk_set(j), .jk_reset(k), .async_preset_n(p), .async_clear_n(c), .q_true(qt), .q_comp(qc));
  initial forever #50 clk = ~clk;
  task automatic chk(logic [3:0] seen, logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD q exp %h seen %h", exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic drive(logic [1:0] nc_k, dj, dk, dp, dc, logic [3:0] e);
    @(posedge clk);
    ck <= nc_k;
    j <= dj;
    k <= dk;
    p <= dp;
    c <= dc;
    repeat (4) @(posedge clk);
    ex.push_back(e);
  endtask : drive
  always @(negedge clk)
    if (ex.size() > 0)
      chk({qt, qc}, ex.pop_front());
  initial begin
    #200000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(76407));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int r = 0; r < 40; r++) begin
      nj = 2'($urandom);
      nk = 2'($urandom);
      f = 2'($urandom);
      drive(2'h3, nj, nk, 2'h3, 2'h3, {m, ~m});
      for (int i = 0; i < 2; i++)
        if (f[i]) m[i] = (nj[i] & nk[i]) ? ~m[i] : (nj[i] | nk[i]) ? nj[i] : m[i];
      drive(~f, nj, nk, 2'h3, 2'h3, {m, ~m});
      drive(2'h3, 2'($urandom), 2'($urandom), 2'h3, 2'h3, {m, ~m});
    end
    $display("edge test done");
    drive(2'h0, 2'h3, 2'h3, 2'h1, 2'h2, 4'h9);
    drive(2'h3, 2'h3, 2'h3, 2'h1, 2'h2, 4'h9);
    drive(2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 4'hf);
    drive(2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 4'hc);
    drive(2'h0, 2'h3, 2'h3, 2'h3, 2'h3, 4'h3);
    @(posedge clk);
    $display("override test done");
    report_and_stop;
  end
endmodule : tb
bind dual_jk_flip_flop jk_chk #(.NUM_FF(NUM_FF)) jk_chk_inst (.clk, .rst_n, .edge_clock_n,
  .jk_set, .jk_reset, .async_preset_n, .async_clear_n, .q_true, .q_comp);
